// ===== inc/mac_timing_pkg.sv
// Constants, widths and types shared by the channel timing block
package mac_timing_pkg;
    // ------------------------------------------------------------
    // Clock and time base
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;                      // MAC clock period
    localparam int US_NS         = 1000;                    // One microsecond
    localparam int CYCLES_PER_US = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int US_CNT_W      = $clog2(CYCLES_PER_US);   // Divider width
    // ------------------------------------------------------------
    // Default widths and counts
    // ------------------------------------------------------------
    localparam int TSF_W    = 64;                           // TSF timer width
    localparam int NAV_W    = 16;                           // NAV in microseconds
    localparam int IFS_W    = 12;                           // INTERFRAME_SPACING_UNIT and slot, in cycles
    localparam int BO_W     = 10;                           // Backoff slots
    localparam int SLEEP_W  = 32;                           // Sleep count, slow ticks
    localparam int NUM_AC   = 4;                            // Access categories
    localparam int NUM_EVT  = 2;                            // Offset event triggers
    localparam int ARB_W    = 2;                            // Policy code width
    // ------------------------------------------------------------
    // Arbitration policy for simultaneous backoff expiry
    // ------------------------------------------------------------
    typedef enum logic [ARB_W-1:0] {
        arb_high_first,                                     // Highest index wins
        arb_low_first,                                      // Lowest index wins
        arb_round_robin                                     // Rotating priority
    } arb_policy_t;
endpackage

// ===== rtl/wlan_mac_channel_timing.sv
// Channel timing: INTERFRAME_SPACING_UNIT timers, backoff engines, sleep timer, TSF and NAV
//
// How it works
// - INTERFRAME_SPACING_UNIT timers start when medium goes idle
// - Pulses mark exact SIFS and RIFS instants
// - Per-AC backoff decrements per idle slot, else pauses
// - Counter reaching zero grants transmit engine
// - Simultaneous expiry resolved by sequencer-chosen policy
// - Power save stops clock, slow timer counts
// - Sleep expiry restores clock and wakes MAC
// - TSF adopts beacon timestamps on sequencer command
// - TBTT tracked and advanced beside TSF
// - Trigger pulses when TSF reaches programmed offsets
// - NAV updated from received duration fields
// - NAV busy acts as virtual carrier sense
`timescale 1ns/1ps
module wlan_mac_channel_timing #(
    parameter int N_AC  = mac_timing_pkg::NUM_AC,           // Backoff engines
    parameter int N_EVT = mac_timing_pkg::NUM_EVT           // Offset triggers
) (
    input  wire logic                                   clock_in,
    input  wire logic                                   rst_b_in,
    input  wire logic                                   phy_cca_busy_in,
    input  wire logic                                   slow_clk_in,
    input  wire logic [mac_timing_pkg::IFS_W-1:0]       sifs_len_in,
    input  wire logic [mac_timing_pkg::IFS_W-1:0]       rifs_len_in,
    input  wire logic [mac_timing_pkg::IFS_W-1:0]       slot_len_in,
    input  wire logic [N_AC-1:0]                        bo_load_in,
    input  wire logic [N_AC*mac_timing_pkg::BO_W-1:0]   bo_value_in,
    input  wire mac_timing_pkg::arb_policy_t            arb_policy_in,
    input  wire logic                                   sleep_load_in,
    input  wire logic [mac_timing_pkg::SLEEP_W-1:0]     sleep_count_in,
    input  wire logic                                   tsf_adopt_in,
    input  wire logic                                   tsf_advance_in,
    input  wire logic [mac_timing_pkg::TSF_W-1:0]       tsf_value_in,
    input  wire logic                                   tbtt_set_in,
    input  wire logic [mac_timing_pkg::TSF_W-1:0]       tbtt_value_in,
    input  wire logic [mac_timing_pkg::NAV_W-1:0]       beacon_interval_in,
    input  wire logic [N_EVT-1:0]                       evt_set_in,
    input  wire logic [N_EVT*mac_timing_pkg::TSF_W-1:0] evt_time_in,
    input  wire logic                                   nav_update_in,
    input  wire logic                                   nav_reset_in,
    input  wire logic [mac_timing_pkg::NAV_W-1:0]       nav_dur_in,
    output logic                                        sifs_trig_out,
    output logic                                        rifs_trig_out,
    output logic [N_AC-1:0]                             bo_grant_out,
    output logic [N_AC-1:0]                             bo_collide_out,
    output logic [N_AC-1:0]                             bo_active_out,
    output logic                                        mac_clk_en_out,
    output logic                                        wake_out,
    output logic [mac_timing_pkg::TSF_W-1:0]            tsf_out,
    output logic                                        tbtt_out,
    output logic [N_EVT-1:0]                            evt_trig_out,
    output logic                                        nav_busy_out
);
    import mac_timing_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] cca_sync_q;                                 // Channel busy sync
    logic [1:0] slow_sync_q;                                // Slow clock sync
    logic       slow_prev_q;                                // For edge detect
    logic       slow_tick;                                  // Slow clock rising edge

    // Two stages each; only stage 1 is looked at by logic
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cca_sync_q  <= 2'b00;
            slow_sync_q <= 2'b00;
            slow_prev_q <= 1'b0;
        end else begin
            cca_sync_q  <= {cca_sync_q[0], phy_cca_busy_in};
            slow_sync_q <= {slow_sync_q[0], slow_clk_in};
            slow_prev_q <= slow_sync_q[1];
        end
    end
    assign slow_tick = slow_sync_q[1] && !slow_prev_q;

    // ------------------------------------------------------------
    // Microsecond divider
    // ------------------------------------------------------------
    logic [US_CNT_W-1:0] us_cnt_q;                          // Cycle within microsecond
    logic                asleep_q;                          // MAC suspended
    logic                us_tick;                           // One pulse per microsecond

    // Held at zero while asleep: the clock is notionally stopped
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            us_cnt_q <= '0;
        end else if (asleep_q) begin
            us_cnt_q <= '0;
        end else if (us_tick) begin
            us_cnt_q <= '0;
        end else begin
            us_cnt_q <= us_cnt_q + US_CNT_W'(1);
        end
    end
    assign us_tick = !asleep_q && (us_cnt_q == US_CNT_W'(CYCLES_PER_US - 1));

    // ------------------------------------------------------------
    // NAV timer
    // ------------------------------------------------------------
    logic [NAV_W-1:0] nav_q;                                // Remaining NAV, us
    logic [NAV_W-1:0] nav_d;

    // Only a longer duration extends NAV; reset clears it
    always_comb begin
        nav_d = nav_q;
        if (nav_reset_in) begin
            nav_d = '0;
        end else if (nav_update_in && nav_dur_in > nav_q) begin
            nav_d = nav_dur_in;
        end else if (us_tick && nav_q != '0) begin
            nav_d = nav_q - NAV_W'(1);
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            nav_q        <= '0;
            nav_busy_out <= 1'b0;
        end else begin
            nav_q        <= nav_d;
            nav_busy_out <= (nav_d != '0);
        end
    end

    chk_nav_busy_tie: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        nav_busy_out == (nav_q != '0)) else $error("nav busy disagrees with nav");
    chk_nav_count_down: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        us_tick && nav_q != '0 && !nav_update_in && !nav_reset_in |=>
        nav_q == $past(nav_q) - NAV_W'(1)) else $error("nav missed a decrement");

    // ------------------------------------------------------------
    // Interframe spacing timers
    // ------------------------------------------------------------
    logic             idle;                                 // Physical and virtual idle
    logic [IFS_W-1:0] ifs_cnt_q;                            // Cycles since idle began

    // Virtual carrier sense joins the PHY indication
    assign idle = !cca_sync_q[1] && !nav_busy_out;

    // Restarts at every busy period, saturates when idle long
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ifs_cnt_q <= '0;
        end else if (!idle) begin
            ifs_cnt_q <= '0;
        end else if (ifs_cnt_q != '1) begin
            ifs_cnt_q <= ifs_cnt_q + IFS_W'(1);
        end
    end

    // One-cycle start instants for response and burst frames
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sifs_trig_out <= 1'b0;
            rifs_trig_out <= 1'b0;
        end else begin
            sifs_trig_out <= idle && (ifs_cnt_q == sifs_len_in - IFS_W'(1));
            rifs_trig_out <= idle && (ifs_cnt_q == rifs_len_in - IFS_W'(1));
        end
    end

    chk_sifs_idle: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        sifs_trig_out |-> $past(idle) && $past(ifs_cnt_q) == $past(sifs_len_in) - IFS_W'(1))
        else $error("sifs trigger at wrong instant");

    // ------------------------------------------------------------
    // Slot timer and backoff engines
    // ------------------------------------------------------------
    logic [IFS_W-1:0]           slot_cnt_q;                 // Cycle within slot
    logic                       slot_end;                   // Idle slot completed
    logic [N_AC-1:0][BO_W-1:0]  bo_cnt_q;                   // Slots remaining
    logic [N_AC-1:0]            cand;                       // Reach zero this slot
    logic [N_AC-1:0]            win;                        // Arbitration winner
    logic [$clog2(N_AC)-1:0]    rr_ptr_q;                   // Round robin start

    // A busy cycle aborts the slot, so the counters pause
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            slot_cnt_q <= '0;
        end else if (!idle || slot_end) begin
            slot_cnt_q <= '0;
        end else begin
            slot_cnt_q <= slot_cnt_q + IFS_W'(1);
        end
    end
    assign slot_end = idle && (slot_cnt_q == slot_len_in - IFS_W'(1));

    // Pick one of several expiring engines under the given policy
    function automatic logic [N_AC-1:0] pick(input logic [N_AC-1:0] req,
                                             input arb_policy_t pol,
                                             input logic [$clog2(N_AC)-1:0] start);
        logic [N_AC-1:0] res;
        int              idx;
        res = '0;
        for (int k = 0; k < N_AC; k++) begin
            unique case (pol)
                arb_high_first: idx = N_AC - 1 - k;
                arb_low_first:  idx = k;
                default:        idx = (int'(start) + k) % N_AC;
            endcase
            if (res == '0 && req[idx]) begin
                res[idx] = 1'b1;
            end
        end
        return res;
    endfunction

    // Count 1 or 0 at slot end means it hits zero now
    always_comb begin
        for (int i = 0; i < N_AC; i++) begin
            cand[i] = slot_end && bo_active_out[i] && bo_cnt_q[i] <= BO_W'(1);
        end
    end
    assign win = pick(cand, arb_policy_in, rr_ptr_q);

    // Load wins over expiry; losers drop out until reloaded
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            bo_cnt_q      <= '0;
            bo_active_out <= '0;
        end else begin
            for (int i = 0; i < N_AC; i++) begin
                if (bo_load_in[i]) begin
                    bo_cnt_q[i]      <= bo_value_in[i*BO_W +: BO_W];
                    bo_active_out[i] <= 1'b1;
                end else if (cand[i]) begin
                    bo_cnt_q[i]      <= '0;
                    bo_active_out[i] <= 1'b0;
                end else if (slot_end && bo_active_out[i]) begin
                    bo_cnt_q[i] <= bo_cnt_q[i] - BO_W'(1);
                end
            end
        end
    end

    // Grant and collision pulses; pointer moves past the winner
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            bo_grant_out   <= '0;
            bo_collide_out <= '0;
            rr_ptr_q       <= '0;
        end else begin
            bo_grant_out   <= win;
            bo_collide_out <= cand & ~win;
            for (int i = 0; i < N_AC; i++) begin
                if (win[i]) begin
                    rr_ptr_q <= $clog2(N_AC)'((i + 1) % N_AC);
                end
            end
        end
    end

    chk_grant_onehot: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        $onehot0(bo_grant_out) && (bo_grant_out & bo_collide_out) == '0)
        else $error("more than one backoff grant");
    chk_backoff_pause: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        !idle && bo_load_in == '0 |=> $stable(bo_cnt_q))
        else $error("backoff moved while medium busy");
    chk_grant_needs_cand: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        cand != '0 |=> bo_grant_out != '0) else $error("expiry without grant");

    // ------------------------------------------------------------
    // Power save sleep timer
    // ------------------------------------------------------------
    logic [SLEEP_W-1:0] sleep_cnt_q;                        // Slow ticks left

    // Counts on slow edges only; the fast domain is stopped
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            asleep_q       <= 1'b0;
            sleep_cnt_q    <= '0;
            mac_clk_en_out <= 1'b1;
            wake_out       <= 1'b0;
        end else begin
            wake_out <= 1'b0;
            if (sleep_load_in && !asleep_q) begin
                asleep_q       <= 1'b1;
                sleep_cnt_q    <= sleep_count_in;
                mac_clk_en_out <= 1'b0;
            end else if (asleep_q && slow_tick) begin
                if (sleep_cnt_q <= SLEEP_W'(1)) begin
                    asleep_q       <= 1'b0;
                    mac_clk_en_out <= 1'b1;
                    wake_out       <= 1'b1;
                    sleep_cnt_q    <= '0;
                end else begin
                    sleep_cnt_q <= sleep_cnt_q - SLEEP_W'(1);
                end
            end
        end
    end

    sequence enter_sleep_s;
        sleep_load_in && !asleep_q ##1 asleep_q && !mac_clk_en_out;
    endsequence
    sequence leave_sleep_s;
        $fell(asleep_q) && wake_out && mac_clk_en_out;
    endsequence
    chk_sleep_enter: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        sleep_load_in && !asleep_q |-> enter_sleep_s) else $error("sleep not entered");
    chk_sleep_wake: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        asleep_q && slow_tick && sleep_cnt_q <= SLEEP_W'(1) |=> leave_sleep_s)
        else $error("no wake on expiry");

    // ------------------------------------------------------------
    // TSF timer, TBTT and offset events
    // ------------------------------------------------------------
    logic [TSF_W-1:0] tbtt_q;                               // Next beacon time
    logic [N_EVT-1:0] evt_armed_q;                          // Event waiting

    // Adopt beats advance beats counting; sleep time is added by advance
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tsf_out <= '0;
        end else if (tsf_adopt_in) begin
            tsf_out <= tsf_value_in;
        end else if (tsf_advance_in) begin
            tsf_out <= tsf_out + tsf_value_in;
        end else if (us_tick) begin
            tsf_out <= tsf_out + TSF_W'(1);
        end
    end

    // Greater-or-equal so a forward jump cannot skip an event
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tbtt_q   <= '0;
            tbtt_out <= 1'b0;
        end else begin
            tbtt_out <= 1'b0;
            if (tbtt_set_in) begin
                tbtt_q <= tbtt_value_in;
            end else if (beacon_interval_in != '0 && tsf_out >= tbtt_q) begin
                tbtt_q   <= tbtt_q + TSF_W'(beacon_interval_in);
                tbtt_out <= 1'b1;
            end
        end
    end

    logic [N_EVT-1:0][TSF_W-1:0] evt_time_q;                // Programmed offsets

    // Each event fires once per arming
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            evt_time_q   <= '0;
            evt_armed_q  <= '0;
            evt_trig_out <= '0;
        end else begin
            for (int e = 0; e < N_EVT; e++) begin
                evt_trig_out[e] <= 1'b0;
                if (evt_set_in[e]) begin
                    evt_time_q[e]  <= evt_time_in[e*TSF_W +: TSF_W];
                    evt_armed_q[e] <= 1'b1;
                end else if (evt_armed_q[e] && tsf_out >= evt_time_q[e]) begin
                    evt_armed_q[e]  <= 1'b0;
                    evt_trig_out[e] <= 1'b1;
                end
            end
        end
    end

    chk_tsf_hold: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        !tsf_adopt_in && !tsf_advance_in && !us_tick |=> $stable(tsf_out))
        else $error("tsf changed without cause");
    chk_tsf_tick: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        us_tick && !tsf_adopt_in && !tsf_advance_in |=> tsf_out == $past(tsf_out) + TSF_W'(1))
        else $error("tsf missed a microsecond");
    chk_evt_fire: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        evt_armed_q[0] && !evt_set_in[0] && tsf_out >= evt_time_q[0] |=> evt_trig_out[0])
        else $error("offset event not raised");
endmodule

// ===== dv/phy_slow_model.sv
// Behavioural channel detector and slow sleep clock facing the timing block
`timescale 1ns/1ps
module phy_slow_model (
    input  wire logic clock_in,
    input  wire logic busy_req_in,
    input  wire logic slow_run_in,
    output logic      phy_cca_busy_out,
    output logic      slow_clk_out
);
    // ------------------------------------------------------------
    // Medium activity and slow clock
    // ------------------------------------------------------------
    int slow_cnt = 0;                       // MAC cycles within a slow half period
    // Updated on the rising edge so the block never sees a race with the bench
    always @(posedge clock_in) begin
        phy_cca_busy_out <= busy_req_in;
    end
    // Slow clock stands low unless the MAC sleeps; 16 MAC cycles a period
    always @(posedge clock_in) begin
        if (!slow_run_in) begin
            slow_cnt     <= 0;
            slow_clk_out <= 1'b0;
        end else if (slow_cnt == 7) begin
            slow_cnt     <= 0;
            slow_clk_out <= ~slow_clk_out;
        end else begin
            slow_cnt <= slow_cnt + 1;
        end
    end
endmodule

// ===== dv/test_wlan_mac_channel_timing.sv
// Self-checking bench for the channel timing block
`timescale 1ns/1ps
module test_wlan_mac_channel_timing;
    import mac_timing_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic             clock_in, rst_b_in, busy_req, slow_run, cca, slow_clk;
    logic [IFS_W-1:0] sifs_len, rifs_len, slot_len;
    logic [3:0]       bo_load, bo_grant, bo_collide, bo_active;
    logic [39:0]      bo_value;
    arb_policy_t      arb_policy;
    logic             sleep_load, tsf_adopt, tsf_advance, tbtt_set, nav_update, nav_reset;
    logic [31:0]      sleep_count;
    logic [63:0]      tsf_value, tbtt_value, t0, tsf;
    logic [127:0]     evt_time;
    logic [1:0]       evt_set, evt_trig;
    logic [15:0]      beacon_interval, nav_dur;
    logic             sifs_trig, rifs_trig, mac_clk_en, wake, tbtt, nav_busy;
    int               err_total = 0, total_checks = 0, cycles = 0, hit;
    wire  [7:0]       watch = {evt_trig, tbtt, wake, |bo_grant, nav_busy, rifs_trig, sifs_trig};

    phy_slow_model partner (.clock_in(clock_in), .busy_req_in(busy_req),
        .slow_run_in(slow_run), .phy_cca_busy_out(cca), .slow_clk_out(slow_clk));
    wlan_mac_channel_timing dut (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .phy_cca_busy_in(cca), .slow_clk_in(slow_clk), .sifs_len_in(sifs_len),
        .rifs_len_in(rifs_len), .slot_len_in(slot_len), .bo_load_in(bo_load),
        .bo_value_in(bo_value), .arb_policy_in(arb_policy), .sleep_load_in(sleep_load),
        .sleep_count_in(sleep_count), .tsf_adopt_in(tsf_adopt), .tsf_advance_in(tsf_advance),
        .tsf_value_in(tsf_value), .tbtt_set_in(tbtt_set), .tbtt_value_in(tbtt_value),
        .beacon_interval_in(beacon_interval), .evt_set_in(evt_set), .evt_time_in(evt_time),
        .nav_update_in(nav_update), .nav_reset_in(nav_reset), .nav_dur_in(nav_dur),
        .sifs_trig_out(sifs_trig), .rifs_trig_out(rifs_trig), .bo_grant_out(bo_grant),
        .bo_collide_out(bo_collide), .bo_active_out(bo_active), .mac_clk_en_out(mac_clk_en),
        .wake_out(wake), .tsf_out(tsf), .tbtt_out(tbtt), .evt_trig_out(evt_trig),
        .nav_busy_out(nav_busy));
    // ------------------------------------------------------------
    // Clock, hang guard and shared tasks
    // ------------------------------------------------------------
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    // Whole run needs about 11300 cycles; a hang ends the run as a failure
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            test_done();
        end
    end
    task automatic test_done();
        $display("Checks made %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock_in);
    endtask
    // Waits up to n cycles for one watched output; hit is the wait, -1 if never
    task automatic wait_for(input int sel, input int n);
        hit = -1;
        for (int k = 1; k <= n && hit < 0; k++) begin
            cyc(1);
            if (watch[sel] === 1'b1) hit = k;
        end
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_nav();
        nav_dur = 16'h0002;
        nav_update = 1'b1;
        cyc(1);
        nav_dur = 16'h0001;                  // Shorter duration must be ignored
        cyc(1);
        nav_update = 1'b0;
        check(nav_busy, 1);
        cyc(88);
        check(nav_busy, 1);
        for (hit = 0; hit < 130 && nav_busy !== 1'b0; hit++) cyc(1);
        check(hit < 130, 1);
        nav_dur = 16'h0005;
        nav_update = 1'b1;
        cyc(1);
        nav_update = 1'b0;
        nav_reset = 1'b1;
        cyc(1);
        nav_reset = 1'b0;
        check(nav_busy, 0);
    endtask
    task automatic t_ifs();
        int r;
        busy_req = 1'b1;
        cyc(6);
        busy_req = 1'b0;
        wait_for(1, 40);
        r = hit;
        wait_for(0, 40);
        check(r, rifs_len + 3);
        check(hit, 2);
        busy_req = 1'b1;
        nav_dur = 16'h0003;
        nav_update = 1'b1;
        cyc(1);
        nav_update = 1'b0;
        busy_req = 1'b0;
        wait_for(0, 40);
        check(hit, -1);
        nav_reset = 1'b1;
        cyc(1);
        nav_reset = 1'b0;
        wait_for(0, 40);
        check(hit > 0, 1);
    endtask
    // Loads the masked engines with two slots and judges the race outcome
    task automatic bo_race(input arb_policy_t p, input logic [3:0] m, input logic [3:0] g);
        arb_policy = p;
        bo_load = m;
        cyc(1);
        bo_load = 4'h0;
        check(bo_active, m);
        wait_for(3, 60);
        check(bo_grant, g);
        check(bo_collide, m & ~g & {4{|g}});
    endtask
    task automatic t_bo();
        bo_race(arb_low_first, 4'b0011, 4'b0001);
        bo_race(arb_high_first, 4'b1100, 4'b1000);
        bo_race(arb_round_robin, 4'b1100, 4'b0100);
        busy_req = 1'b1;
        bo_race(arb_low_first, 4'b0001, 4'b0000);
        check(hit, -1);
        busy_req = 1'b0;
        wait_for(3, 60);
        check(bo_grant, 4'b0001);
    endtask
    task automatic t_tsf();
        tsf_value = 64'h0000_0001_0000_0000;
        tsf_adopt = 1'b1;
        cyc(1);
        tsf_adopt = 1'b0;
        check(tsf, tsf_value);
        cyc(250);
        check((tsf - tsf_value) inside {64'h2, 64'h3}, 1);
        tbtt_value = tsf + 64'h3;
        evt_time = {tsf + 64'h0000_03E8, tsf + 64'h1};
        beacon_interval = 16'h0064;
        {tbtt_set, evt_set} = 3'b111;
        cyc(1);
        {tbtt_set, evt_set} = 3'b000;
        wait_for(6, 150);
        check({hit > 0, evt_trig[1]}, 2'b10);
        wait_for(5, 400);
        check(hit inside {[50:305]}, 1);
        wait_for(5, 10100);
        check(hit, 10000);
        beacon_interval = 16'h0000;
        wait_for(6, 300);
        check(hit, -1);
    endtask
    task automatic t_sleep();
        sleep_count = 32'h0000_0003;
        sleep_load = 1'b1;
        cyc(1);
        sleep_load = 1'b0;
        check(mac_clk_en, 0);
        t0 = tsf;
        slow_run = 1'b1;
        wait_for(4, 400);
        slow_run = 1'b0;
        check({hit > 20, mac_clk_en}, 2'b11);
        check(tsf, t0);
        tsf_value = 64'h0000_0000_0000_0032;
        tsf_advance = 1'b1;
        cyc(1);
        tsf_advance = 1'b0;
        check((tsf - t0 - tsf_value) <= 64'h1, 1);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {busy_req, slow_run, bo_load, sleep_load, tsf_adopt, tsf_advance, tbtt_set} = '0;
        {nav_update, nav_reset, evt_set, sleep_count, tsf_value, tbtt_value} = '0;
        {evt_time, beacon_interval, nav_dur, rst_b_in} = '0;
        arb_policy = arb_low_first;
        bo_value = {4{10'h002}};
        sifs_len = 12'h005;
        rifs_len = 12'h003;
        slot_len = 12'h004;
        cyc(12);
        check({sifs_trig, rifs_trig, bo_grant, bo_collide, bo_active, wake, tbtt, evt_trig,
            nav_busy, mac_clk_en}, 64'h1);
        check(tsf, 64'h0);
        rst_b_in = 1'b1;
        cyc(3);
        t_nav();
        t_ifs();
        t_bo();
        t_tsf();
        t_sleep();
        test_done();
    end
endmodule
